// File: rtl/nai_irq_ctrl.sv
// The APB interface to the registers was left to the implementer.
`default_nettype none

module nai_irq_ctrl #(
  parameter int PHASES = nai_pkg::PHASES,
  parameter int THR_W  = nai_pkg::THR_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [nai_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [nai_pkg::DATA_W-1:0]  pwdata,
  output logic      [nai_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [PHASES-1:0]           energy_lsb,
  input  wire logic                        noload_tick,
  input  wire logic [31:0]                 event_first_set,
  input  wire logic [31:0]                 event_second_set,
  input  wire logic                        sw_reset_done,
  input  wire logic [15:0]                 power_sign_in,
  input  wire logic [15:0]                 phase_event_in,
  input  wire logic [31:0]                 current_peak_in,
  input  wire logic [31:0]                 voltage_peak_in,
  output logic                             irq_first_n,
  output logic                             irq_second_n,
  output logic      [PHASES-1:0]           apparent_accum_en,
  output logic      [PHASES-1:0]           apparent_pulse_en
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [nai_pkg::NUM_REGS-1:0] reg_sel(
    input logic [nai_pkg::ADDR_W-1:0] addr
  );
    logic [15:0]                 idx;
    logic                        aligned;
    logic [nai_pkg::NUM_REGS-1:0] sel;
    idx     = addr[17:2];
    aligned = (addr[1:0] == 2'h0) && (addr[19:18] == 2'h0);
    sel     = '0;
    if (aligned)
    begin
      sel[nai_pkg::SEL_CPEAK] = (idx == nai_pkg::IDX_CURRENT_PEAK_VALUE);
      sel[nai_pkg::SEL_VOLTAGE_PEAK_VALUE] = (idx == nai_pkg::IDX_VOLTAGE_PEAK_VALUE);
      sel[nai_pkg::SEL_FLG0]  = (idx == nai_pkg::IDX_EVENT_FLAGS_FIRST);
      sel[nai_pkg::SEL_FLG1]  = (idx == nai_pkg::IDX_EVENT_FLAGS_SECOND);
      sel[nai_pkg::SEL_ENA0]  = (idx == nai_pkg::IDX_IRQ_ENABLE_FIRST);
      sel[nai_pkg::SEL_ENA1]  = (idx == nai_pkg::IDX_IRQ_ENABLE_SECOND);
      sel[nai_pkg::SEL_PHEV]  = (idx == nai_pkg::IDX_PHASE_EVENT_STATUS);
      sel[nai_pkg::SEL_NLPH]  = (idx == nai_pkg::IDX_NOLOAD_PHASE_STATUS);
      sel[nai_pkg::SEL_SIGN]  = (idx == nai_pkg::IDX_POWER_SIGN_STATUS);
      sel[nai_pkg::SEL_THR]   = (idx == nai_pkg::IDX_APPARENT_NOLOAD_THRESHOLD);
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [nai_pkg::NUM_REGS-1:0] sel;
  logic                         setup_phase;
  logic                         access_done;
  logic                         wr_en;
  logic [31:0]                  flags_first_q;
  logic [31:0]                  flags_first_d;
  logic [31:0]                  flags_second_q;
  logic [31:0]                  flags_second_d;
  logic [31:0]                  enable_first_q;
  logic [31:0]                  enable_second_q;
  logic [31:0]                  enable_second_eff;
  logic [31:0]                  clr_first;
  logic [31:0]                  clr_second;
  logic [31:0]                  set_second;
  logic [THR_W-1:0]             threshold_q;
  logic [PHASES-1:0]            noload_d;
  logic [PHASES-1:0]            noload_q;
  logic                         noload_change;
  logic                         reset_seen_q;
  logic                         reset_done_event;
  logic [15:0]                  noload_status;
  logic [31:0]                  rd_mux;

  assign sel         = reg_sel(paddr);
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_en       = access_done && pwrite && !pslverr;

  // ----------------------------------------------------------------
  // Per-phase apparent no-load detectors
  // ----------------------------------------------------------------
  generate
    for (genvar ph = 0; ph < PHASES; ph++)
    begin : g_phase
      nai_noload_det #(
        .THR_W       (THR_W)
      ) u_det (
        .pclk        (pclk),
        .presetn     (presetn),
        .threshold   (threshold_q),
        .energy_lsb  (energy_lsb[ph]),
        .noload_tick (noload_tick),
        .noload_d    (noload_d[ph]),
        .noload_q    (noload_q[ph])
      );
    end
  endgenerate

  // Status bits and flag take the same next value edge, so they agree
  assign noload_change = |(noload_d ^ noload_q);

  always_comb
  begin
    noload_status = '0;
    noload_status[nai_pkg::POS_APPARENT_NOLOAD_PHASE +: PHASES] = noload_q;
  end

  // ----------------------------------------------------------------
  // Stop accumulation and pulses of a phase held in no-load
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apparent_accum_en <= '1;
      apparent_pulse_en <= '1;
    end
    else
    begin
      apparent_accum_en <= ~noload_d;
      apparent_pulse_en <= ~noload_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset-done event, fired once after each hardware reset release and whenever sw_reset_done is high
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_seen_q <= 1'b0;
    end
    else
    begin
      reset_seen_q <= 1'b1;
    end
  end

  assign reset_done_event = !reset_seen_q || sw_reset_done;

  // ----------------------------------------------------------------
  // Event flags: set wins over a same-cycle clear
  // ----------------------------------------------------------------
  assign clr_first  = (wr_en && sel[nai_pkg::SEL_FLG0]) ? pwdata : 32'h0000_0000;
  assign clr_second = (wr_en && sel[nai_pkg::SEL_FLG1]) ? pwdata : 32'h0000_0000;

  always_comb
  begin
    set_second = event_second_set;
    set_second[nai_pkg::BIT_APPARENT_NOLOAD_FLAG] =
      event_second_set[nai_pkg::BIT_APPARENT_NOLOAD_FLAG] || noload_change;
    set_second[nai_pkg::BIT_RESET_DONE_EVENT] =
      event_second_set[nai_pkg::BIT_RESET_DONE_EVENT] || reset_done_event;
  end

  // Sets ignore the enables, so software can poll masked events
  assign flags_first_d  = (flags_first_q & ~clr_first) | event_first_set;
  assign flags_second_d = (flags_second_q & ~clr_second) | set_second;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_first_q  <= nai_pkg::RST_FLAGS_FIRST;
      flags_second_q <= nai_pkg::RST_FLAGS_SECOND;
    end
    else
    begin
      flags_first_q  <= flags_first_d;
      flags_second_q <= flags_second_d;
    end
  end

  // ----------------------------------------------------------------
  // Enable masks and threshold
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_first_q  <= nai_pkg::RST_ENABLE;
      enable_second_q <= nai_pkg::RST_ENABLE;
    end
    else
    begin
      if (wr_en && sel[nai_pkg::SEL_ENA0])
      begin
        enable_first_q <= pwdata;
      end
      if (wr_en && sel[nai_pkg::SEL_ENA1])
      begin
        enable_second_q <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      threshold_q <= nai_pkg::RST_THRESHOLD;
    end
    else if (wr_en && sel[nai_pkg::SEL_THR])
    begin
      threshold_q <= pwdata[THR_W-1:0];
    end
  end

  // Reset-done is always enabled whatever the stored bit says
  always_comb
  begin
    enable_second_eff = enable_second_q;
    enable_second_eff[nai_pkg::BIT_RESET_DONE_EVENT] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Interrupt lines, active low, level held while any cause remains
  // ----------------------------------------------------------------
  // Driven from next flag state so the line follows the flag edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_first_n  <= 1'b1;
      irq_second_n <= 1'b1;
    end
    else
    begin
      irq_first_n  <= ~|(flags_first_d & enable_first_q);
      irq_second_n <= ~|(flags_second_d & enable_second_eff);
    end
  end

  // ----------------------------------------------------------------
  // Read mux; phase indicator registers pass the paired fields through
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = nai_pkg::UNMAPPED_READ;
    case (1'b1)
      sel[nai_pkg::SEL_CPEAK]:
      begin
        rd_mux = current_peak_in;
      end
      sel[nai_pkg::SEL_VOLTAGE_PEAK_VALUE]:
      begin
        rd_mux = voltage_peak_in;
      end
      sel[nai_pkg::SEL_FLG0]:
      begin
        rd_mux = flags_first_q;
      end
      sel[nai_pkg::SEL_FLG1]:
      begin
        rd_mux = flags_second_q;
      end
      sel[nai_pkg::SEL_ENA0]:
      begin
        rd_mux = enable_first_q;
      end
      sel[nai_pkg::SEL_ENA1]:
      begin
        rd_mux = enable_second_q;
      end
      sel[nai_pkg::SEL_PHEV]:
      begin
        rd_mux = {16'h0000, phase_event_in};
      end
      sel[nai_pkg::SEL_NLPH]:
      begin
        rd_mux = {16'h0000, noload_status};
      end
      sel[nai_pkg::SEL_SIGN]:
      begin
        rd_mux = {16'h0000, power_sign_in};
      end
      sel[nai_pkg::SEL_THR]:
      begin
        rd_mux = {{(32-THR_W){1'b0}}, threshold_q};
      end
      default:
      begin
        rd_mux = nai_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase after every setup
  // ----------------------------------------------------------------
  // Read data are sampled at setup, so a flag that rises during the
  // access phase shows on the next read, never lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= nai_pkg::UNMAPPED_READ;
    end
    else
    begin
      pready <= setup_phase;
      if (setup_phase)
      begin
        pslverr <= ~|sel;
        prdata  <= pwrite ? nai_pkg::UNMAPPED_READ : rd_mux;
      end
      else if (access_done)
      begin
        pslverr <= 1'b0;
        prdata  <= nai_pkg::UNMAPPED_READ;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/nai_pkg.sv
`default_nettype none

package nai_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address on the bus is four times these
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CURRENT_PEAK_VALUE        = 16'hE500;
  localparam logic [15:0] IDX_VOLTAGE_PEAK_VALUE        = 16'hE501;
  localparam logic [15:0] IDX_EVENT_FLAGS_FIRST         = 16'hE502;
  localparam logic [15:0] IDX_EVENT_FLAGS_SECOND        = 16'hE503;
  localparam logic [15:0] IDX_IRQ_ENABLE_FIRST          = 16'hE50A;
  localparam logic [15:0] IDX_IRQ_ENABLE_SECOND         = 16'hE50B;
  localparam logic [15:0] IDX_PHASE_EVENT_STATUS        = 16'hE600;
  localparam logic [15:0] IDX_NOLOAD_PHASE_STATUS       = 16'hE608;
  localparam logic [15:0] IDX_POWER_SIGN_STATUS         = 16'hE617;
  localparam logic [15:0] IDX_APPARENT_NOLOAD_THRESHOLD = 16'hE90A;

  localparam int          ADDR_W    = 20;
  localparam int          DATA_W    = 32;
  localparam int          NUM_REGS  = 10;
  localparam int          THR_W     = 16;
  localparam int          PHASES    = 3;

  // ----------------------------------------------------------------
  // One-hot register selects
  // ----------------------------------------------------------------
  localparam int          SEL_CPEAK = 0;
  localparam int          SEL_VOLTAGE_PEAK_VALUE = 1;
  localparam int          SEL_FLG0  = 2;
  localparam int          SEL_FLG1  = 3;
  localparam int          SEL_ENA0  = 4;
  localparam int          SEL_ENA1  = 5;
  localparam int          SEL_PHEV  = 6;
  localparam int          SEL_NLPH  = 7;
  localparam int          SEL_SIGN  = 8;
  localparam int          SEL_THR   = 9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          BIT_APPARENT_NOLOAD_FLAG   = 2;
  localparam int          BIT_RESET_DONE_EVENT       = 15;
  localparam int          POS_APPARENT_NOLOAD_PHASE  = 6;
  localparam int          PH_REG_W                   = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_FLAGS_FIRST  = 32'h0000_0000;
  localparam logic [31:0] RST_FLAGS_SECOND = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLE       = 32'h0000_0000;
  localparam logic [15:0] RST_THRESHOLD    = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

endpackage

`default_nettype wire

// File: rtl/nai_noload_det.sv
`default_nettype none

module nai_noload_det #(
  parameter int THR_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [THR_W-1:0] threshold,
  input  wire logic             energy_lsb,
  input  wire logic             noload_tick,
  output logic                  noload_d,
  output logic                  noload_q
);

  localparam logic [THR_W-1:0] CNT_MAX = {THR_W{1'b1}};

  logic [THR_W-1:0] cnt_q;
  logic [THR_W-1:0] cnt_d;

  // ----------------------------------------------------------------
  // Idle timer: counts ticks from the threshold up to all ones
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_d    = cnt_q;
    noload_d = noload_q;
    if (threshold == '0)
    begin
      // Zero threshold turns detection off entirely
      cnt_d    = threshold;
      noload_d = 1'b0;
    end
    else if (energy_lsb)
    begin
      // Any energy gain restarts the timer and leaves no-load
      cnt_d    = threshold;
      noload_d = 1'b0;
    end
    else if (noload_tick && !noload_q)
    begin
      if (cnt_q == CNT_MAX)
      begin
        noload_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= '0;
      noload_q <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      noload_q <= noload_d;
    end
  end

endmodule

`default_nettype wire

// File: tb/nai_irq_ctrl_sva.sv
`default_nettype none

module nai_irq_ctrl_sva #(
  parameter int PHASES = nai_pkg::PHASES
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [nai_pkg::ADDR_W-1:0] paddr,
  input wire logic [nai_pkg::DATA_W-1:0] pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [PHASES-1:0]          energy_lsb,
  input wire logic                       noload_tick,
  input wire logic                       irq_first_n,
  input wire logic                       irq_second_n,
  input wire logic [PHASES-1:0]          apparent_accum_en,
  input wire logic [PHASES-1:0]          apparent_pulse_en
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Shadow of host writes
  // ----------------------------------------------------------------
  localparam logic [19:0] A_F1 = {2'h0, nai_pkg::IDX_EVENT_FLAGS_FIRST, 2'h0};
  localparam logic [19:0] A_F2 = {2'h0, nai_pkg::IDX_EVENT_FLAGS_SECOND, 2'h0};
  localparam logic [19:0] A_E1 = {2'h0, nai_pkg::IDX_IRQ_ENABLE_FIRST, 2'h0};
  localparam logic [19:0] A_E2 = {2'h0, nai_pkg::IDX_IRQ_ENABLE_SECOND, 2'h0};
  localparam logic [19:0] A_TH = {2'h0, nai_pkg::IDX_APPARENT_NOLOAD_THRESHOLD, 2'h0};

  logic        wr_hit;
  logic [31:0] en1_q;
  logic [31:0] en2_q;
  logic [15:0] thr_q;

  // Refused writes must not move the shadow, or the masks drift apart
  assign wr_hit = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en1_q <= 32'h0000_0000;
      en2_q <= 32'h0000_0000;
      thr_q <= 16'h0000;
    end
    else if (wr_hit)
    begin
      if (paddr == A_E1)
        en1_q <= pwdata;
      if (paddr == A_E2)
        en2_q <= pwdata;
      if (paddr == A_TH)
        thr_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not exactly one cycle after setup");
  chk_accum_pulse_tie: assert property (apparent_accum_en == apparent_pulse_en)
    else $error("accumulation and pulse enables differ");
  chk_lsb_leaves_noload: assert property (|energy_lsb |=>
    (apparent_accum_en & $past(energy_lsb)) == $past(energy_lsb))
    else $error("phase with new energy still blocked");
  chk_entry_on_tick: assert property (|($past(apparent_accum_en) & ~apparent_accum_en) |->
    $past(noload_tick) && $past(thr_q) != 16'h0000)
    else $error("no-load entered without tick or with zero threshold");
  chk_change_irq_two: assert property ($changed(apparent_accum_en) && en2_q[2] &&
    $past(en2_q[2]) |-> !irq_second_n)
    else $error("line two high after enabled no-load change");
  chk_reset_done_low: assert property ($rose(presetn) |-> ##[1:3] !irq_second_n)
    else $error("line two not lowered after reset");
  chk_irq_one_hold: assert property ($rose(irq_first_n) |->
    $past(wr_hit && (paddr == A_F1 || paddr == A_E1)))
    else $error("line one released without host write");
  chk_irq_two_hold: assert property ($rose(irq_second_n) |->
    $past(wr_hit && (paddr == A_F2 || paddr == A_E2)))
    else $error("line two released without host write");
  chk_irq_one_mask: assert property ($fell(irq_first_n) |-> (en1_q | $past(en1_q)) != 0)
    else $error("line one lowered with all enables off");

  cov_noload_entry: cover property (|($past(apparent_accum_en) & ~apparent_accum_en));
  cov_irq_one_low: cover property ($fell(irq_first_n));
  cov_refused: cover property (pready && pslverr);
endmodule

bind nai_irq_ctrl nai_irq_ctrl_sva #(.PHASES(PHASES)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .energy_lsb(energy_lsb), .noload_tick(noload_tick), .irq_first_n(irq_first_n),
  .irq_second_n(irq_second_n), .apparent_accum_en(apparent_accum_en),
  .apparent_pulse_en(apparent_pulse_en)
);

`default_nettype wire

// File: tb/nai_host_model.sv
`default_nettype none

module nai_host_model #(
  parameter logic [31:0] FULL_SCALE_POWER_CONSTANT = 32'h019B_DAA7
) (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [19:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             timeout_hit
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h00000;
    pwdata = 32'h0000_0000;
    timeout_hit = 1'b0;
  end

  // Request held until pready is seen or 16 cycles pass; a missing answer is then flagged
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    if (n >= 16)
      timeout_hit <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Flags first, indicator next, clearing write last
  task automatic service(input logic [15:0] flg, input logic [15:0] ph);
    logic [31:0] v;
    logic [31:0] p;
    xfer(1'b0, flg, 32'h0000_0000, v);
    xfer(1'b0, ph, 32'h0000_0000, p);
    xfer(1'b1, flg, v, p);
  endtask

  function automatic logic [15:0] thr_calc(input logic [31:0] y, input logic [31:0] apparent_energy_threshold);
    logic [63:0] q;
    q = {32'h0, y} * {32'h0, apparent_energy_threshold} * 64'h0000_0000_0002_0000;
    q = q / {32'h0, FULL_SCALE_POWER_CONSTANT};
    return 16'hFFFF - q[15:0];
  endfunction
endmodule

`default_nettype wire

// File: tb/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] F1 = nai_pkg::IDX_EVENT_FLAGS_FIRST;
  localparam logic [15:0] F2 = nai_pkg::IDX_EVENT_FLAGS_SECOND;
  localparam logic [15:0] E1 = nai_pkg::IDX_IRQ_ENABLE_FIRST;
  localparam logic [15:0] E2 = nai_pkg::IDX_IRQ_ENABLE_SECOND;
  localparam logic [15:0] TH = nai_pkg::IDX_APPARENT_NOLOAD_THRESHOLD;
  localparam logic [15:0] NL = nai_pkg::IDX_NOLOAD_PHASE_STATUS;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, noload_tick;
  logic        sw_reset_done, irq_first_n, irq_second_n, timeout_hit;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, event_first_set, event_second_set;
  logic [31:0] current_peak_in, voltage_peak_in, m;
  logic [15:0] power_sign_in, phase_event_in, thr;
  logic [2:0]  energy_lsb, apparent_accum_en, apparent_pulse_en, m3;
  logic [32:0] notes[$];
  int          num_errors = 0;
  int          cmp_count = 0;

  nai_irq_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .energy_lsb(energy_lsb), .noload_tick(noload_tick), .event_first_set(event_first_set),
    .event_second_set(event_second_set), .sw_reset_done(sw_reset_done),
    .power_sign_in(power_sign_in), .phase_event_in(phase_event_in),
    .current_peak_in(current_peak_in), .voltage_peak_in(voltage_peak_in),
    .irq_first_n(irq_first_n), .irq_second_n(irq_second_n),
    .apparent_accum_en(apparent_accum_en), .apparent_pulse_en(apparent_pulse_en)
  );

  nai_host_model i_host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .timeout_hit(timeout_hit)
  );

  // ----------------------------------------------------------------
  // Checking and helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Each completed transfer is matched with the oldest note
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      check({pslverr, pwrite ? 32'h0000_0000 : prdata},
            notes.size() > 0 ? notes.pop_front() : 33'h1_FFFF_FFFF);
    if (timeout_hit === 1'b1)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    logic [31:0] d;
    notes.push_back(33'h0_0000_0000);
    i_host.xfer(1'b1, idx, v, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [32:0] e);
    logic [31:0] d;
    notes.push_back(e);
    i_host.xfer(1'b0, idx, 32'h0000_0000, d);
  endtask

  task automatic lines(input logic e1, input logic e2);
    @(posedge pclk);
    @(negedge pclk);
    check({31'h0, irq_first_n, irq_second_n}, {31'h0, e1, e2});
  endtask

  task automatic en(input logic [2:0] e);
    @(posedge pclk);
    @(negedge pclk);
    check({27'h0, apparent_accum_en, apparent_pulse_en}, {27'h0, e, e});
  endtask

  task automatic ev(input int r, input logic [31:0] v);
    @(posedge pclk);
    if (r == 1)
      event_second_set <= v;
    else
      event_first_set <= v;
    @(posedge pclk);
    event_first_set <= 32'h0000_0000;
    event_second_set <= 32'h0000_0000;
  endtask

  task automatic lsb(input logic [2:0] v);
    @(posedge pclk);
    energy_lsb <= v;
    @(posedge pclk);
    energy_lsb <= 3'h0;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      noload_tick <= 1'b1;
      @(posedge pclk);
      noload_tick <= 1'b0;
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    energy_lsb = 3'h0;
    noload_tick = 1'b0;
    event_first_set = 32'h0000_0000;
    event_second_set = 32'h0000_0000;
    sw_reset_done = 1'b0;
    void'($urandom(27));
    power_sign_in = 16'($urandom);
    phase_event_in = 16'($urandom);
    current_peak_in = $urandom;
    voltage_peak_in = $urandom;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    lines(1'b1, 1'b0);
    rd(F2, 33'h0_0000_8000);
    rd(E1, 33'h0_0000_0000);
    rd(E2, 33'h0_0000_0000);
    wr(F2, 32'h0000_7FFF);
    lines(1'b1, 1'b0);
    wr(F2, 32'h0000_8000);
    lines(1'b1, 1'b1);
    @(posedge pclk);
    sw_reset_done <= 1'b1;
    @(posedge pclk);
    sw_reset_done <= 1'b0;
    lines(1'b1, 1'b0);
    rd(F2, 33'h0_0000_8000);
    wr(F2, 32'h0000_8000);
    for (int r = 0; r < 2; r++)
    begin
      m = 32'h0000_0001 << $urandom_range(31, 3);
      if (m == 32'h0000_8000)
        m = 32'h0001_0000;
      ev(r, m);
      lines(1'b1, 1'b1);
      rd(r ? F2 : F1, {1'b0, m});
      wr(r ? E2 : E1, m);
      lines(r[0], !r[0]);
      wr(r ? F2 : F1, ~m);
      lines(r[0], !r[0]);
      fork
        wr(r ? F2 : F1, m);
        begin
          @(posedge pclk);
          ev(r, m);
        end
      join
      lines(r[0], !r[0]);
      wr(r ? F2 : F1, m);
      lines(1'b1, 1'b1);
      ev(r, m);
      lines(r[0], !r[0]);
      wr(r ? F2 : F1, m);
      wr(r ? E2 : E1, 32'h0000_0000);
    end
    wr(nai_pkg::IDX_CURRENT_PEAK_VALUE, 32'hFFFF_FFFF);
    rd(nai_pkg::IDX_CURRENT_PEAK_VALUE, {1'b0, current_peak_in});
    rd(nai_pkg::IDX_VOLTAGE_PEAK_VALUE, {1'b0, voltage_peak_in});
    rd(nai_pkg::IDX_PHASE_EVENT_STATUS, {17'h0, phase_event_in});
    rd(nai_pkg::IDX_POWER_SIGN_STATUS, {17'h0, power_sign_in});
    rd(16'hE504, 33'h1_0000_0000);
    thr = i_host.thr_calc(32'h0000_0001, 32'h0000_0190);
    m3 = 3'($urandom_range(7, 1));
    wr(E2, 32'h0000_0004);
    wr(TH, {16'h0, thr});
    rd(TH, {17'h0, thr});
    lsb(m3);
    tick(32'h0001_0000 - {16'h0, thr});
    en(~m3);
    lines(1'b1, 1'b0);
    rd(F2, 33'h0_0000_0004);
    rd(NL, {1'b0, 23'h0, m3, 6'h00});
    notes.push_back(33'h0_0000_0004);
    notes.push_back({1'b0, 23'h0, m3, 6'h00});
    notes.push_back(33'h0_0000_0000);
    i_host.service(F2, NL);
    lines(1'b1, 1'b1);
    lsb(m3);
    en(3'h7);
    lines(1'b1, 1'b0);
    rd(NL, 33'h0_0000_0000);
    wr(F2, 32'h0000_0004);
    lsb(3'h7);
    tick(2);
    en(3'h0);
    wr(TH, 32'h0000_0000);
    en(3'h7);
    lsb(3'h7);
    tick(2);
    en(3'h7);
    wr(F2, 32'h0000_0004);
    lines(1'b1, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    lines(1'b1, 1'b0);
    check(33'(notes.size()), 33'h0_0000_0000);
    test_done();
  end
endmodule

`default_nettype wire
